// >>> verilog/ssdm_monitor.sv
// Purpose: dual-channel safe stop monitor, trips and indications
// Assumes: contact closed = 1, reset and key inputs synchronous
// Notes:   trip reset acts on the release of the reset input

`timescale 1ns/1ps
`default_nettype none

module ssdm_monitor
    import ssdm_pkg::*;
#(
    parameter int unsigned JUDGE_CYCLES = JUDGE_CYCLES_DEF
)(
    input  wire logic         clock,                    // system clock
    input  wire logic         sys_rst,                  // power-on reset
    input  wire logic         safe_stop_input_a,        // contact a
    input  wire logic         safe_stop_input_b,        // contact b
    input  wire logic         internal_fault,           // path fault
    input  wire logic [2:0]   safe_stop_reaction_select,// mode
    input  wire logic [7:0]   release_delay_allowance,  // 10 ms units
    input  wire logic         trip_reset_input,         // reset input
    input  wire logic         stop_reset_key,           // front key
    output logic              alarm_trip_indicator,     // trip active
    output ssdm_trip_t        trip_code,                // held trip
    output ssdm_disp_t        display_code,             // indication
    output ssdm_status_t      input_status,             // status
    output ssdm_event_t       events,                   // pulses
    output logic              channel_discrepancy_out,  // discrepancy
    output logic              recovery_locked           // mode 05 lock
);

    ////////////////////////////////////////////////////////////////////
    // declarations
    logic [1:0]    sync_w;
    logic          in_a;
    logic          in_b;
    ssdm_status_t  status_now;
    ssdm_status_t  status_r;
    logic          status_changed;
    logic          one_open;

    logic          mode_trip;
    logic          mode_mis;
    logic          mode_show;
    logic          mode_delay;
    logic          mode_timed;

    logic          clr_prev_r;
    logic          key_prev_r;
    logic          clear_req;

    ssdm_trip_t    trip_r;
    ssdm_trip_t    trip_nxt;
    logic          set_fail;
    logic          set_sto;
    logic          set_mis;
    logic          alarm_r;

    logic          restoring_r;
    logic          restoring_nxt;
    logic          lock_r;
    logic          lock_nxt;
    ssdm_disp_t    disp_r;
    ssdm_disp_t    disp_nxt;
    logic          late_shown;

    logic [JUDGE_W-1:0] div_r;
    logic          tick;
    logic [ALLOW_W-1:0] allow_c;
    logic [ALLOW_W-1:0] cnt_r;
    logic [ALLOW_W-1:0] cnt_nxt;
    logic          counting;
    logic          timeout_fire;

    ssdm_event_t   ev_nxt;
    ssdm_event_t   ev_r;
    logic          disc_r;
    logic          disc_nxt;
    logic          disc_judge;

    ////////////////////////////////////////////////////////////////////
    // input synchroniser
    ssdm_sync u_sync (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .raw_in   ({safe_stop_input_b, safe_stop_input_a}),
        .sync_out (sync_w)
    );

    assign in_a = sync_w[0];
    assign in_b = sync_w[1];

    ////////////////////////////////////////////////////////////////////
    // combined status; a found fault outranks both contacts
    assign status_now =
        internal_fault   ? IN_FAILURE     :
        (in_a && in_b)   ? IN_BOTH_CLOSED :
        (!in_a && in_b)  ? IN_A_OPEN      :
        (in_a && !in_b)  ? IN_B_OPEN      :
                           IN_BOTH_OPEN;

    assign status_changed = (status_now != status_r);
    assign one_open = (status_now == IN_A_OPEN) ||
                      (status_now == IN_B_OPEN);

    ////////////////////////////////////////////////////////////////////
    // mode decode; unused codes fall back to no reaction
    assign mode_trip  = (safe_stop_reaction_select == MODE_TRIP);
    assign mode_mis   = (safe_stop_reaction_select == MODE_MISMATCH);
    // modes 03 and 04 share one decode
    assign mode_show  = (safe_stop_reaction_select == MODE_SHOW_A) ||
                        (safe_stop_reaction_select == MODE_SHOW_B);
    assign mode_timed = (safe_stop_reaction_select == MODE_TIMED);
    assign mode_delay = mode_timed ||
                        (safe_stop_reaction_select == MODE_DELAY);

    ////////////////////////////////////////////////////////////////////
    // reset input release or key press clears
    assign clear_req = (clr_prev_r && !trip_reset_input) ||
                       (!key_prev_r && stop_reset_key);

    assign set_fail = (status_now == IN_FAILURE);
    // shut-off trip when either input open
    // mode 01 trips, indication stays clear
    assign set_sto  = mode_trip &&
                      (one_open || status_now == IN_BOTH_OPEN);
    assign set_mis  = mode_mis && one_open;

    ////////////////////////////////////////////////////////////////////
    // trip priority: failure, then a live cause, then a clear;
    // a cause still present wins over a clear in the same cycle
    always_comb begin
        trip_nxt = trip_r;
        if (set_fail) begin
            trip_nxt = TRIP_FAILURE;
        // failure trip ignores reset and key
        end else if (trip_r == TRIP_FAILURE) begin
            trip_nxt = TRIP_FAILURE;
        end else if (set_sto) begin
            trip_nxt = TRIP_STO;
        end else if (set_mis) begin
            trip_nxt = TRIP_MISMATCH;
        end else if (clear_req) begin
            trip_nxt = TRIP_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // direction tracking: stop seen means the next single open input
    // belongs to a restoration, closed seen means a transition to stop
    assign restoring_nxt =
        (status_now == IN_BOTH_OPEN)             ? 1'b1 :
        (status_now == IN_BOTH_CLOSED && !lock_r) ? 1'b0 :
                                                   restoring_r;

    // lock holds until both inputs open again
    assign lock_nxt =
        (timeout_fire && mode_timed)  ? 1'b1 :
        (status_now == IN_BOTH_OPEN)  ? 1'b0 :
                                        lock_r;

    ////////////////////////////////////////////////////////////////////
    // indication per status and mode
    always_comb begin
        disp_nxt = DISP_NONE;
        case (status_now)
            IN_BOTH_OPEN: begin
                // stop shown in modes 02 to 06 only
                if (mode_mis || mode_show || mode_delay) begin
                    disp_nxt = DISP_STOP;
                end
            end
            IN_A_OPEN: begin
                if (mode_delay) begin
                    disp_nxt = restoring_nxt ? DISP_A_LATE_CLOSE
                                             : DISP_B_LATE_OPEN;
                end
            end
            IN_B_OPEN: begin
                if (mode_delay) begin
                    disp_nxt = restoring_nxt ? DISP_B_LATE_CLOSE
                                             : DISP_A_LATE_OPEN;
                end
            end
            IN_BOTH_CLOSED: begin
                // locked recovery keeps the delay code
                if (lock_r) begin
                    disp_nxt = disp_r;
                end
            end
            default: begin
                disp_nxt = DISP_NONE;
            end
        endcase
    end

    assign late_shown = (disp_r != DISP_NONE) &&
                        (disp_r != DISP_STOP);

    ////////////////////////////////////////////////////////////////////
    // 10 ms judgement tick
    assign tick = (div_r == JUDGE_W'(JUDGE_CYCLES - 1));

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            div_r <= '0;
        end else begin
            div_r <= tick ? '0 : div_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // allowance limited to 2.00 s
    assign allow_c = (release_delay_allowance > ALLOW_MAX) ?
                     ALLOW_MAX : release_delay_allowance;

    // only a restoration in mode 05 is timed; a status change restarts
    // the count so it measures how long one status is held
    assign counting = mode_timed && restoring_nxt && one_open &&
                      !lock_r;

    assign timeout_fire = counting && !status_changed && tick &&
                          (cnt_r >= allow_c);

    assign cnt_nxt = (!counting || status_changed) ? '0 :
                     (tick && cnt_r != ALLOW_MAX)  ? cnt_r + 1'b1 :
                                                     cnt_r;

    ////////////////////////////////////////////////////////////////////
    // event pulses on status changes and on a mode 05 timeout
    always_comb begin
        ev_nxt = '0;
        ev_nxt.discrepancy = status_changed && one_open;
        ev_nxt.stop        = status_changed &&
                             (status_now == IN_BOTH_OPEN);
        ev_nxt.failure     = status_changed &&
                             (status_now == IN_FAILURE);
        ev_nxt.timeout     = timeout_fire;
    end

    ////////////////////////////////////////////////////////////////////
    // discrepancy output judged on the tick only, so a short glitch
    // between ticks never reaches the output
    // modes 05/06 drop on trip or delay
    assign disc_judge = (trip_r == TRIP_NONE) &&
                        !(mode_delay && late_shown);
    assign disc_nxt   = tick ? disc_judge : disc_r;

    ////////////////////////////////////////////////////////////////////
    // state registers; power-on reset is the only power cycle here
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            status_r    <= IN_BOTH_CLOSED;
            clr_prev_r  <= 1'b0;
            key_prev_r  <= 1'b0;
            trip_r      <= TRIP_NONE;
            alarm_r     <= 1'b0;
        end else begin
            status_r    <= status_now;
            clr_prev_r  <= trip_reset_input;
            key_prev_r  <= stop_reset_key;
            trip_r      <= trip_nxt;
            alarm_r     <= (trip_nxt != TRIP_NONE);
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            restoring_r <= 1'b0;
            lock_r      <= 1'b0;
            disp_r      <= DISP_NONE;
            cnt_r       <= '0;
        end else begin
            restoring_r <= restoring_nxt;
            lock_r      <= lock_nxt;
            disp_r      <= disp_nxt;
            cnt_r       <= cnt_nxt;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ev_r   <= '0;
            disc_r <= DISC_RST_VAL;
        end else begin
            ev_r   <= ev_nxt;
            disc_r <= disc_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs, all from flops
    assign alarm_trip_indicator    = alarm_r;
    assign trip_code               = trip_r;
    assign display_code            = disp_r;
    assign input_status            = status_r;
    assign events                  = ev_r;
    assign channel_discrepancy_out = disc_r;
    assign recovery_locked         = lock_r;

endmodule // ssdm_monitor

`default_nettype wire

// >>> pkg/ssdm_pkg.sv
// What this block does
// - internal fault always raises failure trip
// - shut-off mode trips when either input opens
// - mismatch mode trips when inputs disagree
// - reset pulse, key or power clears trips
// - failure trip cleared only by power cycle
// - flag late closing of each input
// - flag late opening of each input
// - event when exactly one input opens
// - stop event; indicate stop in most modes
// - event on entering detected-failure status
// - timeout event only in mode 05
// - modes 05/06 drop output on trip/delay
// - discrepancy output updated every 10 ms
// - other modes hold output active unless tripped
// - mode 00 trips only on internal fault, never indicates
// - mode 01 trips without special indication
// - mode 05 timeout blocks recovery until both open
// - release allowance 0.00 to 2.00 s
//
// Purpose: shared constants and types of the safe stop monitor
// Assumes: 125 MHz system clock, contact closed reads as 1
// Notes:   allowance is counted in 10 ms steps, 200 steps max

package ssdm_pkg;

    ////////////////////////////////////////////////////////////////////
    // reaction select codes
    localparam logic [2:0] MODE_NONE     = 3'h0;
    localparam logic [2:0] MODE_TRIP     = 3'h1;
    localparam logic [2:0] MODE_MISMATCH = 3'h2;
    localparam logic [2:0] MODE_SHOW_A   = 3'h3;
    localparam logic [2:0] MODE_SHOW_B   = 3'h4;
    localparam logic [2:0] MODE_TIMED    = 3'h5;
    localparam logic [2:0] MODE_DELAY    = 3'h6;

    ////////////////////////////////////////////////////////////////////
    // timing
    localparam int unsigned CLOCK_KHZ       = 125000;
    localparam int unsigned JUDGE_PERIOD_MS = 10;
    localparam int unsigned JUDGE_CYCLES_DEF =
        JUDGE_PERIOD_MS * CLOCK_KHZ;
    localparam int unsigned JUDGE_W         = 21;
    localparam int unsigned ALLOW_W         = 8;
    // allowance step equals the judgement period, 2.00 s max
    localparam int unsigned ALLOW_MAX_MS    = 2000;
    localparam logic [7:0]  ALLOW_MAX       =
        8'(ALLOW_MAX_MS / JUDGE_PERIOD_MS);

    ////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic SYNC_RST_VAL = 1'b1;
    localparam logic DISC_RST_VAL = 1'b1;

    ////////////////////////////////////////////////////////////////////
    // combined input status
    typedef enum logic [2:0] {
        IN_BOTH_CLOSED,
        IN_A_OPEN,
        IN_B_OPEN,
        IN_BOTH_OPEN,
        IN_FAILURE
    } ssdm_status_t;

    // trip held by the monitor
    typedef enum logic [1:0] {
        TRIP_NONE,
        TRIP_STO,
        TRIP_MISMATCH,
        TRIP_FAILURE
    } ssdm_trip_t;

    // special indication
    typedef enum logic [2:0] {
        DISP_NONE,
        DISP_STOP,
        DISP_A_LATE_CLOSE,
        DISP_B_LATE_CLOSE,
        DISP_A_LATE_OPEN,
        DISP_B_LATE_OPEN
    } ssdm_disp_t;

    // one-cycle event pulses
    typedef struct packed {
        logic failure;
        logic stop;
        logic discrepancy;
        logic timeout;
    } ssdm_event_t;

endpackage

// >>> verilog/ssdm_sync.sv
// Purpose: two-stage synchroniser for the two safety contacts
// Assumes: inputs may change at any time relative to clock
// Notes:   first stage feeds only the second stage

`timescale 1ns/1ps
`default_nettype none

module ssdm_sync
    import ssdm_pkg::*;
(
    input  wire logic       clock,    // system clock
    input  wire logic       sys_rst,  // async reset, high
    input  wire logic [1:0] raw_in,   // contact levels
    output logic      [1:0] sync_out  // synchronised levels
);

    ////////////////////////////////////////////////////////////////////
    // two flop stages
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_bit
            logic meta_r;
            logic hold_r;
            always_ff @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    meta_r <= SYNC_RST_VAL;
                    hold_r <= SYNC_RST_VAL;
                end else begin
                    meta_r <= raw_in[gi];
                    hold_r <= meta_r;
                end
            end
            assign sync_out[gi] = hold_r;
        end
    endgenerate

endmodule // ssdm_sync

`default_nettype wire

// >>> tb/ssdm_contacts.sv
// Purpose: model of the two external safety contacts
// Assumes: contacts change just after the falling clock edge
// Notes:   contact b may lag its command to mimic a slow relay

`timescale 1ns/1ps
`default_nettype none

module ssdm_contacts (
    input  wire logic       clock,     // system clock
    input  wire logic       want_a,    // commanded level a
    input  wire logic       want_b,    // commanded level b
    input  wire logic [7:0] lag_b,     // cycles b lags behind
    output logic            contact_a, // contact a, 1 closed
    output logic            contact_b  // contact b, 1 closed
);
    logic [7:0] wait_r;

    // both contacts start closed, as at power-up of the machine
    initial begin
        contact_a = 1'b1;
        contact_b = 1'b1;
        wait_r = 8'h00;
    end

    // b moves only after lag_b cycles of a pending command
    always @(negedge clock) begin
        contact_a <= want_a;
        if (want_b == contact_b) begin
            wait_r <= 8'h00;
        end else if (wait_r >= lag_b) begin
            contact_b <= want_b;
            wait_r <= 8'h00;
        end else begin
            wait_r <= wait_r + 8'h01;
        end
    end
endmodule // ssdm_contacts

`default_nettype wire

// >>> tb/ssdm_monitor_asserts.sv
// Purpose: port-level checks of the safe stop monitor
// Assumes: one clock domain, reset acts as power cycle
// Notes:   own divider mirrors the judgement tick

`timescale 1ns/1ps
`default_nettype none

module ssdm_monitor_asserts
    import ssdm_pkg::*;
#(
    parameter int unsigned JUDGE_CYCLES = JUDGE_CYCLES_DEF
)(
    input  wire logic         clock,                     // clock
    input  wire logic         sys_rst,                   // reset
    input  wire logic         internal_fault,            // fault
    input  wire logic [2:0]   safe_stop_reaction_select, // mode
    input  wire logic         alarm_trip_indicator,      // alarm
    input  wire ssdm_trip_t   trip_code,                 // trip
    input  wire ssdm_disp_t   display_code,              // display
    input  wire ssdm_status_t input_status,              // status
    input  wire ssdm_event_t  events,                    // pulses
    input  wire logic         channel_discrepancy_out    // output
);
    logic [JUDGE_W-1:0] div_r;
    wire tick = (div_r == JUDGE_W'(JUDGE_CYCLES - 1));
    wire single = input_status inside {IN_A_OPEN, IN_B_OPEN};
    wire [2:0] mode = safe_stop_reaction_select;
    // only the late codes sit above the stop code
    wire disc_want = (trip_code == TRIP_NONE) &&
        !((mode == MODE_TIMED || mode == MODE_DELAY) &&
          display_code > DISP_STOP);

    // divider restarts with reset, so the phase matches the design
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) div_r <= '0;
        else if (tick) div_r <= '0;
        else div_r <= div_r + 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    a_fail_trip: assert property (internal_fault |=>
        trip_code == TRIP_FAILURE && input_status == IN_FAILURE)
        else $error("failure trip missing");
    a_fail_sticky: assert property (trip_code == TRIP_FAILURE |=>
        trip_code == TRIP_FAILURE) else $error("failure trip lost");
    a_alarm_held: assert property (
        alarm_trip_indicator == (trip_code != TRIP_NONE))
        else $error("alarm differs from trip");
    a_sto_trip: assert property (mode == MODE_TRIP &&
        $past(mode) == MODE_TRIP && $changed(input_status) &&
        input_status != IN_BOTH_CLOSED |->
        trip_code inside {TRIP_STO, TRIP_FAILURE})
        else $error("shut-off trip missing");
    a_mismatch_trip: assert property (mode == MODE_MISMATCH &&
        $past(mode) == MODE_MISMATCH && $changed(input_status) &&
        single |-> trip_code inside {TRIP_MISMATCH, TRIP_FAILURE})
        else $error("mismatch trip missing");
    a_disc_event: assert property (events.discrepancy ==
        ($changed(input_status) && single))
        else $error("discrepancy event wrong");
    a_stop_event: assert property (events.stop ==
        ($changed(input_status) && input_status == IN_BOTH_OPEN))
        else $error("stop event wrong");
    a_fail_event: assert property (events.failure ==
        ($changed(input_status) && input_status == IN_FAILURE))
        else $error("failure event wrong");
    a_timeout_mode: assert property (events.timeout |->
        $past(mode) == MODE_TIMED) else $error("timeout outside mode 5");
    a_disc_hold: assert property (!$past(tick) |->
        $stable(channel_discrepancy_out))
        else $error("output moved between ticks");
    a_disc_value: assert property ($past(tick) |->
        channel_discrepancy_out == $past(disc_want))
        else $error("output value wrong after tick");

    c_timeout: cover property (events.timeout);
    c_failure: cover property (trip_code == TRIP_FAILURE);
    c_mismatch: cover property (trip_code == TRIP_MISMATCH);
endmodule // ssdm_monitor_asserts

bind ssdm_monitor ssdm_monitor_asserts #(.JUDGE_CYCLES(JUDGE_CYCLES))
    u_asserts (.clock(clock), .sys_rst(sys_rst),
    .internal_fault(internal_fault),
    .safe_stop_reaction_select(safe_stop_reaction_select),
    .alarm_trip_indicator(alarm_trip_indicator),
    .trip_code(trip_code), .display_code(display_code),
    .input_status(input_status), .events(events),
    .channel_discrepancy_out(channel_discrepancy_out));

`default_nettype wire

// >>> tb/ssdm_monitor_bench.sv
// Purpose: self-checking bench of the safe stop monitor
// Assumes: short judgement period of 16 cycles
// Notes:   reset check, table rows, then clear, failure, power cycle and timeout cases

`timescale 1ns/1ps
`default_nettype none

module ssdm_monitor_bench;
    import ssdm_pkg::*;
    localparam int unsigned JC = 16;
    typedef struct packed {ssdm_trip_t t; ssdm_disp_t d;} ssdm_exp_t;
    localparam ssdm_exp_t NN = '{TRIP_NONE, DISP_NONE};
    localparam ssdm_exp_t TS = '{TRIP_STO, DISP_NONE};
    localparam ssdm_exp_t MM = '{TRIP_MISMATCH, DISP_NONE};
    localparam ssdm_exp_t SS = '{TRIP_NONE, DISP_STOP};
    localparam ssdm_exp_t LB = '{TRIP_NONE, DISP_B_LATE_OPEN};
    localparam ssdm_exp_t LA = '{TRIP_NONE, DISP_A_LATE_OPEN};
    // row = mode; columns: a open, b open, both open
    localparam ssdm_exp_t ROWS [8][3] = '{'{NN, NN, NN}, '{TS, TS, TS},
        '{MM, MM, SS}, '{NN, NN, SS}, '{NN, NN, SS}, '{LB, LA, SS},
        '{LB, LA, SS}, '{NN, NN, NN}};
    localparam ssdm_status_t STAT [3] = '{IN_A_OPEN, IN_B_OPEN,
        IN_BOTH_OPEN};

    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic want_a = 1'b1;
    logic want_b = 1'b1;
    logic fault = 1'b0;
    logic clr_in = 1'b0;
    logic key = 1'b0;
    logic [7:0] lag = 8'h00;
    logic [7:0] allow = 8'hC8;
    logic [2:0] mode = 3'h0;
    logic contact_a, contact_b, alarm, disc, lock;
    ssdm_trip_t trip;
    ssdm_disp_t disp;
    ssdm_status_t status;
    ssdm_event_t ev;
    int err_total = 0;
    int samples_checked = 0;

    always #4 clock = ~clock;

    ssdm_contacts u_contacts (.clock(clock), .want_a(want_a),
        .want_b(want_b), .lag_b(lag), .contact_a(contact_a),
        .contact_b(contact_b));

    ssdm_monitor #(.JUDGE_CYCLES(JC)) dut (.clock(clock),
        .sys_rst(sys_rst), .safe_stop_input_a(contact_a),
        .safe_stop_input_b(contact_b), .internal_fault(fault),
        .safe_stop_reaction_select(mode),
        .release_delay_allowance(allow), .trip_reset_input(clr_in),
        .stop_reset_key(key), .alarm_trip_indicator(alarm),
        .trip_code(trip), .display_code(disp), .input_status(status),
        .events(ev), .channel_discrepancy_out(disc),
        .recovery_locked(lock));

    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic ok, input string what);
        samples_checked++;
        if (ok !== 1'b1) begin
            $display("ERROR %0t %s", $time, what);
            err_total++;
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge clock);
    endtask

    // clear acts on the release of the reset input
    task automatic pulse_clear();
        clr_in <= 1'b1;
        settle(1);
        clr_in <= 1'b0;
        settle(2);
    endtask

    task automatic press_key();
        key <= 1'b1;
        settle(1);
        key <= 1'b0;
        settle(2);
    endtask

    task automatic conclude();
        if (err_total == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // the full run needs about 5000 cycles; allow a wide margin
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        conclude();
    end

    initial begin
        int m;
        int s;
        ssdm_exp_t e;
        settle(12);
        check(alarm === 1'b0 && trip === TRIP_NONE && disp === DISP_NONE
            && ev === 4'h0 && disc === 1'b1 && lock === 1'b0, "reset");
        sys_rst <= 1'b0;
        settle(5);
        for (m = 0; m < 8; m++) begin
            for (s = 0; s < 3; s++) begin
                mode <= 3'(m);
                settle(2);
                want_a <= (s == 1);
                want_b <= (s == 0);
                settle(8);
                e = ROWS[m][s];
                check(trip === e.t, "row trip");
                check(disp === e.d, "row disp");
                check(status === STAT[s], "row status");
                check(alarm === (e.t != TRIP_NONE), "row alarm");
                settle(2 * JC + 2);
                check(disc === (e.t == TRIP_NONE && e.d inside
                    {DISP_NONE, DISP_STOP}), "row disc");
                want_a <= 1'b1;
                want_b <= 1'b1;
                settle(8);
                pulse_clear();
                check(trip === TRIP_NONE, "row clear");
            end
        end
        // a clear while the cause stays is refused, the key clears later
        mode <= MODE_MISMATCH;
        want_a <= 1'b0;
        settle(8);
        pulse_clear();
        check(trip === TRIP_MISMATCH, "cause kept trip");
        want_a <= 1'b1;
        settle(8);
        press_key();
        check(trip === TRIP_NONE && alarm === 1'b0, "key clear");
        // failure trip survives both clears, only reset removes it
        mode <= MODE_NONE;
        fault <= 1'b1;
        settle(3);
        check(trip === TRIP_FAILURE && status === IN_FAILURE, "fail");
        fault <= 1'b0;
        settle(4);
        pulse_clear();
        press_key();
        check(trip === TRIP_FAILURE && alarm === 1'b1, "fail kept");
        sys_rst <= 1'b1;
        settle(2);
        sys_rst <= 1'b0;
        settle(5);
        check(trip === TRIP_NONE && alarm === 1'b0, "power cycle");
        // slow contact b in mode 5 runs past the allowance and locks
        mode <= MODE_TIMED;
        allow <= 8'h02;
        want_a <= 1'b0;
        want_b <= 1'b0;
        settle(8);
        check(disp === DISP_STOP, "stop shown");
        lag <= 8'h64;
        want_a <= 1'b1;
        want_b <= 1'b1;
        settle(10);
        check(disp === DISP_B_LATE_CLOSE, "b late close");
        settle(80);
        check(lock === 1'b1 && disc === 1'b0, "locked");
        settle(30);
        check(lock === 1'b1 && disp === DISP_B_LATE_CLOSE, "held");
        // the outside party opens both contacts to leave the lock
        lag <= 8'h00;
        want_a <= 1'b0;
        want_b <= 1'b0;
        settle(8);
        check(lock === 1'b0 && disp === DISP_STOP, "unlocked");
        // mode 6 flags the late contact but never times out
        mode <= MODE_DELAY;
        want_b <= 1'b1;
        settle(8);
        check(disp === DISP_A_LATE_CLOSE, "a late close");
        settle(100);
        check(lock === 1'b0, "no timeout in mode 6");
        // allowance above 2.00 s is clamped: lock near 201 ticks, not 256
        mode <= MODE_TIMED;
        allow <= 8'hFF;
        want_b <= 1'b0;
        settle(8);
        want_a <= 1'b1;
        settle(204 * JC);
        check(lock === 1'b1, "allowance clamp");
        want_a <= 1'b0;
        settle(8);
        conclude();
    end
endmodule // ssdm_monitor_bench

`default_nettype wire
